// >>> design/emtrk_dpram.sv
/*
 * Dual-ported sample buffer: bank 0 holds samples heading for the bus,
 * bank 1 holds samples heading for the codecs.
 * Assumes both ports are on the card clock; read data are registered.
 */
`timescale 1ns/1ps
module emtrk_dpram (
    // Clock
    input  wire logic                          clk,
    // Backplane-side port
    input  wire logic                          a_we,
    input  wire logic [emtrk_pkg::MEM_AW-1:0]   a_addr,
    input  wire logic [emtrk_pkg::SAMPLE_W-1:0] a_wdata,
    output logic      [emtrk_pkg::SAMPLE_W-1:0] a_rdata,
    // Codec-side port
    input  wire logic                          b_we,
    input  wire logic [emtrk_pkg::MEM_AW-1:0]   b_addr,
    input  wire logic [emtrk_pkg::SAMPLE_W-1:0] b_wdata,
    output logic      [emtrk_pkg::SAMPLE_W-1:0] b_rdata
);
    import emtrk_pkg::*;

    logic [SAMPLE_W-1:0] mem [2**MEM_AW];

    // The two sides write disjoint banks in normal use; a clash favours the codec side
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end

endmodule : emtrk_dpram

// >>> design/emtrk_pkg.sv
/*
 * Shared constants and types for the eight-port PCM slot interface.
 * Assumes a 40 MHz card clock, 32 eight-bit slots per backplane frame and
 * codecs that use the first eight bit times of a 256-bit codec frame.
 */
package emtrk_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int PORTS    = 8;
    localparam int SAMPLE_W = 8;
    localparam int SLOT_W   = 5;
    localparam int BIT_W    = 3;
    localparam int PORT_W   = 3;
    localparam int MEM_AW   = 4;
    localparam int SCAN_W   = 4;
    localparam int CB_W     = 8;
    localparam int ASYNC_W  = 4 + 3 * PORTS;
    // Detector leads idle high; their sync stages reset high so release flags no change
    localparam logic [ASYNC_W-1:0] SYNC_IDLE = {4'h0, {PORTS{1'b0}}, {(2 * PORTS){1'b1}}};

    // ************************************************************
    // Codec clock synthesis: phase accumulator at twice the codec rate
    // ************************************************************
    localparam int              REF_CLK_KHZ   = 40000;
    localparam int              CODEC_CLK_KHZ = 2048;
    localparam int              ACC_W         = 16;
    localparam logic [ACC_W-1:0] ACC_MOD      = ACC_W'(REF_CLK_KHZ);
    localparam logic [ACC_W-1:0] ACC_STEP     = ACC_W'(2 * CODEC_CLK_KHZ);

    // ************************************************************
    // Frame positions and buffer layout
    // ************************************************************
    localparam logic [CB_W-1:0]   CODEC_FIRST_BIT = 8'h00;
    localparam logic [CB_W-1:0]   CODEC_LAST_BIT  = 8'h07;
    localparam logic [CB_W-1:0]   CODEC_LOAD_BIT  = 8'hF0;
    localparam logic [CB_W-1:0]   CODEC_IDX_RST   = 8'hFF;
    localparam logic [BIT_W-1:0]  BUS_FIRST_BIT   = 3'h0;
    localparam logic [BIT_W-1:0]  BUS_READ_BIT    = 3'h3;
    localparam logic [BIT_W-1:0]  BUS_LAST_BIT    = 3'h7;
    localparam logic [SCAN_W-1:0] SCAN_LOAD_END   = 4'h8;
    localparam logic [PORT_W-1:0] SCAN_LAST       = 3'h7;
    localparam logic              MEM_TX_BANK     = 1'b0;
    localparam logic              MEM_RX_BANK     = 1'b1;

    typedef enum logic [1:0] {CPH_IDLE, CPH_LOAD, CPH_STORE} emtrk_cphase_type;
    typedef enum logic       {BPH_IDLE, BPH_WRITE}           emtrk_bphase_type;

endpackage : emtrk_pkg

// >>> design/emtrk_top.sv
/*
 * Digital side of an eight-port voice trunk card: PCM slot transmit and
 * listen on two backplane buses, codec serial ports, and per-port
 * signaling relay and detector handling.
 * Assumes the backplane bit clock, frame sync, data and the detector
 * leads are asynchronous to REF_CLK and slow against it (under 4 MHz).
 */
`timescale 1ns/1ps
module emtrk_top (
    // Clock and reset
    input  wire logic                                   REF_CLK,
    input  wire logic                                   RST_N,
    // Card configuration
    input  wire logic [emtrk_pkg::SLOT_W-1:0]            CARD_BASE_SLOT,
    input  wire logic                                   MU_LAW_SEL,
    input  wire logic                                   TRUNK_SIDE,
    // Per-port settings
    input  wire logic [emtrk_pkg::PORTS-1:0]             LISTEN_BUS,
    input  wire logic [emtrk_pkg::PORTS*emtrk_pkg::SLOT_W-1:0] LISTEN_SLOT,
    input  wire logic [emtrk_pkg::PORTS-1:0]             TX_BUS,
    input  wire logic [emtrk_pkg::PORTS-1:0]             RELAY_CTRL,
    // PCM backplane
    input  wire logic                                   PCM_BCLK,
    input  wire logic                                   PCM_FSYNC,
    input  wire logic                                   PCM0_DIN,
    input  wire logic                                   PCM1_DIN,
    output logic                                        PCM0_DOUT,
    output logic                                        PCM0_OE_N,
    output logic                                        PCM1_DOUT,
    output logic                                        PCM1_OE_N,
    // Codecs
    output logic                                        CODEC_CLK,
    output logic                                        CODEC_FS,
    output logic                                        CODEC_MU_LAW,
    output logic      [emtrk_pkg::PORTS-1:0]             CODEC_DOUT,
    input  wire logic [emtrk_pkg::PORTS-1:0]             CODEC_DIN,
    // Signaling
    input  wire logic [emtrk_pkg::PORTS-1:0]             DET_E_N,
    input  wire logic [emtrk_pkg::PORTS-1:0]             DET_M_N,
    output logic      [emtrk_pkg::PORTS-1:0]             PORT_SIGNAL_RELAY_M,
    output logic      [emtrk_pkg::PORTS-1:0]             PORT_SIGNAL_RELAY_E,
    output logic      [emtrk_pkg::PORTS-1:0]             FAR_END_N,
    input  wire logic                                   STATUS_POLL,
    output logic                                        STATUS_VALID,
    output logic      [emtrk_pkg::PORTS-1:0]             STATUS_CHANGE
);
    import emtrk_pkg::*;

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic               rst_q1_reg, rst_n;
    logic [ASYNC_W-1:0] sync1_reg, sync2_reg;
    logic               bclk_s, fsync_s, d0_s, d1_s;
    logic [PORTS-1:0]   cdin_s, det_e_s, det_m_s;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_q1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_q1_reg <= 1'b1;
            rst_n      <= rst_q1_reg;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= {PCM_BCLK, PCM_FSYNC, PCM0_DIN, PCM1_DIN, CODEC_DIN, DET_E_N, DET_M_N};
            sync2_reg <= sync1_reg;
        end
    end
    assign {bclk_s, fsync_s, d0_s, d1_s, cdin_s, det_e_s, det_m_s} = sync2_reg;

    // ************************************************************
    // Sample buffer
    // ************************************************************
    logic                a_we, b_we;
    logic [MEM_AW-1:0]   a_addr, b_addr;
    logic [SAMPLE_W-1:0] a_wdata, b_wdata, a_rdata, b_rdata;

    emtrk_dpram u_buf (
        .clk     (REF_CLK),
        .a_we    (a_we),
        .a_addr  (a_addr),
        .a_wdata (a_wdata),
        .a_rdata (a_rdata),
        .b_we    (b_we),
        .b_addr  (b_addr),
        .b_wdata (b_wdata),
        .b_rdata (b_rdata)
    );

    // ************************************************************
    // Backplane side: slot timing, transmit, listen capture
    // ************************************************************
    logic [BIT_W-1:0]    bit_reg, bit_next;
    logic [SLOT_W-1:0]   slot_reg, slot_next, cap_slot_reg, cap_slot_next, pref_off;
    logic [SAMPLE_W-1:0] rx0_reg, rx0_next, rx1_reg, rx1_next, cap0_reg, cap0_next;
    logic [SAMPLE_W-1:0] cap1_reg, cap1_next, txsh_reg, txsh_next, txw_reg, txw_next;
    logic                bprev_reg, rdpend_reg, rdpend_next, hit_reg, hit_next;
    logic                txbus_reg, txbus_next, dout_next, oe0_next, oe1_next;
    logic [PORT_W-1:0]   bscan_reg, bscan_next;
    emtrk_bphase_type    bph_reg, bph_next;
    logic                b_rise, b_fall;

    assign b_rise   = bclk_s & ~bprev_reg;
    assign b_fall   = ~bclk_s & bprev_reg;
    assign pref_off = SLOT_W'(slot_reg + 1'b1 - CARD_BASE_SLOT);

    always_comb begin
        {bit_next, slot_next, cap_slot_next} = {bit_reg, slot_reg, cap_slot_reg};
        {rx0_next, rx1_next, cap0_next, cap1_next} = {rx0_reg, rx1_reg, cap0_reg, cap1_reg};
        {txsh_next, hit_next, txbus_next, bscan_next} = {txsh_reg, hit_reg, txbus_reg, bscan_reg};
        txw_next    = rdpend_reg ? a_rdata : txw_reg;
        rdpend_next = 1'b0;
        dout_next   = PCM0_DOUT;
        oe0_next    = PCM0_OE_N;
        oe1_next    = PCM1_OE_N;
        bph_next    = bph_reg;
        a_we        = 1'b0;
        a_addr      = {MEM_TX_BANK, pref_off[PORT_W-1:0]};
        a_wdata     = cap0_reg;
        if (b_rise) begin
            if (fsync_s) begin
                {slot_next, bit_next} = '0;
            end else begin
                {slot_next, bit_next} = (SLOT_W+BIT_W)'({slot_reg, bit_reg} + 1'b1);
            end
            if (bit_next == BUS_FIRST_BIT) begin
                txsh_next = txw_reg;
                oe0_next  = ~(hit_reg & ~txbus_reg);
                oe1_next  = ~(hit_reg & txbus_reg);
            end else begin
                txsh_next = txsh_reg << 1;
            end
            dout_next = txsh_next[SAMPLE_W-1];
        end
        if (b_fall) begin
            rx0_next = {rx0_reg[SAMPLE_W-2:0], d0_s};
            rx1_next = {rx1_reg[SAMPLE_W-2:0], d1_s};
            if (bit_reg == BUS_READ_BIT) begin
                rdpend_next = 1'b1;
                hit_next    = (pref_off < SLOT_W'(PORTS));
                txbus_next  = TX_BUS[pref_off[PORT_W-1:0]];
            end
            if (bit_reg == BUS_LAST_BIT) begin
                cap0_next     = rx0_next;
                cap1_next     = rx1_next;
                cap_slot_next = slot_reg;
                bscan_next    = '0;
                bph_next      = BPH_WRITE;
            end
        end
        case (bph_reg)
            BPH_IDLE: begin
            end
            BPH_WRITE: begin
                // One port per cycle, so several ports may share one source
                a_we       = (LISTEN_SLOT[bscan_reg*SLOT_W +: SLOT_W] == cap_slot_reg);
                a_addr     = {MEM_RX_BANK, bscan_reg};
                a_wdata    = LISTEN_BUS[bscan_reg] ? cap1_reg : cap0_reg;
                bscan_next = bscan_reg + 1'b1;
                if (bscan_reg == SCAN_LAST) begin
                    bph_next = BPH_IDLE;
                end
            end
            default: bph_next = BPH_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            {bit_reg, slot_reg, cap_slot_reg, bscan_reg} <= '0;
            {rx0_reg, rx1_reg, cap0_reg, cap1_reg, txsh_reg, txw_reg} <= '0;
            {bprev_reg, rdpend_reg, hit_reg, txbus_reg} <= '0;
            PCM0_DOUT <= 1'b0;
            PCM1_DOUT <= 1'b0;
            PCM0_OE_N <= 1'b1;
            PCM1_OE_N <= 1'b1;
            bph_reg   <= BPH_IDLE;
        end else begin
            {bit_reg, slot_reg, cap_slot_reg, bscan_reg} <=
                {bit_next, slot_next, cap_slot_next, bscan_next};
            {rx0_reg, rx1_reg, cap0_reg, cap1_reg, txsh_reg, txw_reg} <=
                {rx0_next, rx1_next, cap0_next, cap1_next, txsh_next, txw_next};
            {bprev_reg, rdpend_reg, hit_reg, txbus_reg} <= {bclk_s, rdpend_next, hit_next, txbus_next};
            PCM0_DOUT <= dout_next;
            PCM1_DOUT <= dout_next;
            PCM0_OE_N <= oe0_next;
            PCM1_OE_N <= oe1_next;
            bph_reg   <= bph_next;
        end
    end

    // ************************************************************
    // Codec side: 2.048 MHz clock, frame sync, serial shifting
    // ************************************************************
    logic [ACC_W-1:0]    acc_reg, acc_next, acc_sum;
    logic [CB_W-1:0]     idx_reg, idx_next;
    logic [SCAN_W-1:0]   cscan_reg, cscan_next;
    logic [SAMPLE_W-1:0] cout_reg [PORTS];
    logic [SAMPLE_W-1:0] cout_next [PORTS];
    logic [SAMPLE_W-1:0] cin_reg [PORTS];
    logic [SAMPLE_W-1:0] cin_next [PORTS];
    logic [PORTS-1:0]    cdout_next;
    logic                tick, cclk_next, cfs_next;
    emtrk_cphase_type    cph_reg, cph_next;

    assign acc_sum = ACC_W'(acc_reg + ACC_STEP);
    // Fractional divider: edges jitter by one REF_CLK period around 4.096 MHz
    assign tick    = (acc_sum >= ACC_MOD);

    always_comb begin
        acc_next   = tick ? ACC_W'(acc_sum - ACC_MOD) : acc_sum;
        cclk_next  = CODEC_CLK ^ tick;
        idx_next   = idx_reg;
        cfs_next   = CODEC_FS;
        cdout_next = CODEC_DOUT;
        cout_next  = cout_reg;
        cin_next   = cin_reg;
        cscan_next = cscan_reg;
        cph_next   = cph_reg;
        b_we       = 1'b0;
        b_addr     = {MEM_RX_BANK, cscan_reg[PORT_W-1:0]};
        b_wdata    = cin_reg[cscan_reg[PORT_W-1:0]];
        if (tick && !CODEC_CLK) begin
            idx_next = idx_reg + 1'b1;
            cfs_next = (idx_next == CODEC_FIRST_BIT);
            for (int p = 0; p < PORTS; p++) begin
                if (idx_next <= CODEC_LAST_BIT) begin
                    cdout_next[p] = cout_reg[p][SAMPLE_W-1];
                    cout_next[p]  = cout_reg[p] << 1;
                end
            end
            if (idx_next == CODEC_LOAD_BIT) begin
                cscan_next = '0;
                cph_next   = CPH_LOAD;
            end
        end
        if (tick && CODEC_CLK && idx_reg <= CODEC_LAST_BIT) begin
            for (int p = 0; p < PORTS; p++) begin
                cin_next[p] = {cin_reg[p][SAMPLE_W-2:0], cdin_s[p]};
            end
            if (idx_reg == CODEC_LAST_BIT) begin
                cscan_next = '0;
                cph_next   = CPH_STORE;
            end
        end
        case (cph_reg)
            CPH_IDLE: begin
            end
            CPH_LOAD: begin
                // Read data lag the address by one cycle, hence nine steps
                if (cscan_reg != '0) begin
                    cout_next[cscan_reg[PORT_W-1:0] - 1'b1] = b_rdata;
                end
                cscan_next = cscan_reg + 1'b1;
                if (cscan_reg == SCAN_LOAD_END) begin
                    cph_next = CPH_IDLE;
                end
            end
            CPH_STORE: begin
                b_we       = 1'b1;
                b_addr     = {MEM_TX_BANK, cscan_reg[PORT_W-1:0]};
                cscan_next = cscan_reg + 1'b1;
                if (cscan_reg[PORT_W-1:0] == SCAN_LAST) begin
                    cph_next = CPH_IDLE;
                end
            end
            default: cph_next = CPH_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg      <= '0;
            idx_reg      <= CODEC_IDX_RST;
            cscan_reg    <= '0;
            cph_reg      <= CPH_IDLE;
            CODEC_CLK    <= 1'b0;
            CODEC_FS     <= 1'b0;
            CODEC_DOUT   <= '0;
            CODEC_MU_LAW <= 1'b0;
            for (int p = 0; p < PORTS; p++) begin
                cout_reg[p] <= '0;
                cin_reg[p]  <= '0;
            end
        end else begin
            acc_reg      <= acc_next;
            idx_reg      <= idx_next;
            cscan_reg    <= cscan_next;
            cph_reg      <= cph_next;
            CODEC_CLK    <= cclk_next;
            CODEC_FS     <= cfs_next;
            CODEC_DOUT   <= cdout_next;
            CODEC_MU_LAW <= MU_LAW_SEL;
            cout_reg     <= cout_next;
            cin_reg      <= cin_next;
        end
    end

    // ************************************************************
    // Signaling: relays, detectors, change reporting
    // ************************************************************
    // Voice samples above never touch these leads
    logic [PORTS-1:0] det_sel, chg, pend_reg, pend_next;

    assign det_sel = TRUNK_SIDE ? det_e_s : det_m_s;
    assign chg     = det_sel ^ FAR_END_N;

    // A change landing in the poll cycle stays pending for the next poll
    always_comb begin
        pend_next = (STATUS_POLL ? '0 : pend_reg) | chg;
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg            <= '0;
            FAR_END_N           <= '1;
            PORT_SIGNAL_RELAY_M <= '0;
            PORT_SIGNAL_RELAY_E <= '0;
            STATUS_VALID        <= 1'b0;
            STATUS_CHANGE       <= '0;
        end else begin
            pend_reg            <= pend_next;
            FAR_END_N           <= det_sel;
            PORT_SIGNAL_RELAY_M <= RELAY_CTRL & {PORTS{TRUNK_SIDE}};
            PORT_SIGNAL_RELAY_E <= RELAY_CTRL & {PORTS{~TRUNK_SIDE}};
            STATUS_VALID        <= STATUS_POLL;
            STATUS_CHANGE       <= STATUS_POLL ? pend_reg : STATUS_CHANGE;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_ONE_BUS: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        PCM0_OE_N || PCM1_OE_N) else $error("both PCM buses driven");
    AST_OWN_SLOT: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (!PCM0_OE_N || !PCM1_OE_N) |-> (SLOT_W'(slot_reg - CARD_BASE_SLOT) < SLOT_W'(PORTS)))
        else $error("PCM bus driven outside card slots");
    AST_RELAY: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        1'b1 |=> (PORT_SIGNAL_RELAY_M == ($past(RELAY_CTRL) & {PORTS{$past(TRUNK_SIDE)}})))
        else $error("M relay does not follow control on trunk side");
    AST_DET_SEL: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        1'b1 |=> (FAR_END_N == ($past(TRUNK_SIDE) ? $past(det_e_s) : $past(det_m_s))))
        else $error("wrong detector lead reported");
    AST_CHG_KEPT: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (|chg) |=> ((pend_reg & $past(chg)) == $past(chg))) else $error("change event lost");
    AST_POLL: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        STATUS_POLL |=> (STATUS_VALID && STATUS_CHANGE == $past(pend_reg)))
        else $error("poll answer wrong");
    AST_CODEC_RATE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        tick |=> (!tick)[*8] ##[1:2] tick) else $error("codec clock edge spacing off");
    AST_LISTEN_SCAN: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (b_fall && bit_reg == BUS_LAST_BIT) |=> (bph_reg == BPH_WRITE) ##8 (bph_reg == BPH_IDLE))
        else $error("listen scan length wrong");

endmodule : emtrk_top

// >>> verif/emtrk_bus_model.sv
/* Backplane model: bit clock, frame sync and the other cards' samples.
   Assumes a 40 MHz clk; the card's own drive wins while its enable is low. */
`timescale 1ns/1ps
module emtrk_bus_model (
    // Card side
    input  wire logic       clk,
    input  wire logic [1:0] oe_n,
    input  wire logic [1:0] dout,
    // Backplane
    output logic            bclk,
    output logic            fsync,
    output logic [1:0]      din,
    output logic [7:0]      idx
);
    logic [3:0] cnt;

    // ************************************************************
    // Frame timing: 32 slots of 8 bits, 12 clocks per half bit
    // ************************************************************
    initial begin
        {bclk, fsync, idx, cnt} = '0;
    end

    always @(posedge clk) begin
        cnt <= (cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'hB) begin
            bclk <= ~bclk;
            if (!bclk) idx <= idx + 8'h01;
            // Raised half a bit early so the card sees it at the slot 0 rise
            if (bclk) fsync <= (idx == 8'hFF);
        end
    end

    // Sample content names its own source slot and bus
    function automatic logic src_bit(input logic b, input logic [7:0] i);
        logic [7:0] v;
        v = {b, 2'b10, i[7:3]};
        return v[~i[2:0]];
    endfunction : src_bit

    assign din[0] = oe_n[0] ? src_bit(1'b0, idx) : dout[0];
    assign din[1] = oe_n[1] ? src_bit(1'b1, idx) : dout[1];
endmodule : emtrk_bus_model

// >>> verif/test_emtrk_top.sv
/* Self-checking bench for emtrk_top: relays, detectors, status poll,
   codec clock and law, slot transmit and listen. Assumes emtrk_bus_model. */
`timescale 1ns/1ps
module test_emtrk_top;
    logic        clk = 1'b0, rst_n = 1'b0, mu = 1'b0, trunk = 1'b1, poll = 1'b0;
    logic [4:0]  base = 5'h1E;
    logic [7:0]  lbus = 8'h00, txb = 8'hC3, relay = 8'h00, cdin = 8'h5A;
    logic [7:0]  det_e_n = 8'hFF, det_m_n = 8'hFF, idx, cdout, rm, re, far, chg;
    logic [7:0]  heard [8];
    logic [39:0] lslot = 40'h0;
    logic [1:0]  oe_n, dout, din;
    logic [4:0]  off;
    logic        bclk, fsync, cclk, cfs, cmu, valid, armed = 1'b0;
    int          miscompares = 0, cmp_count = 0, ccnt = 0, c0;

    always #12.5 clk = ~clk;
    always @(posedge cclk) ccnt++;

    emtrk_top dut_u (
        .REF_CLK(clk), .RST_N(rst_n), .CARD_BASE_SLOT(base), .MU_LAW_SEL(mu),
        .TRUNK_SIDE(trunk), .LISTEN_BUS(lbus), .LISTEN_SLOT(lslot), .TX_BUS(txb),
        .RELAY_CTRL(relay), .PCM_BCLK(bclk), .PCM_FSYNC(fsync), .PCM0_DIN(din[0]),
        .PCM1_DIN(din[1]), .PCM0_DOUT(dout[0]), .PCM0_OE_N(oe_n[0]),
        .PCM1_DOUT(dout[1]), .PCM1_OE_N(oe_n[1]), .CODEC_CLK(cclk), .CODEC_FS(cfs),
        .CODEC_MU_LAW(cmu), .CODEC_DOUT(cdout), .CODEC_DIN(cdin), .DET_E_N(det_e_n),
        .DET_M_N(det_m_n), .PORT_SIGNAL_RELAY_M(rm), .PORT_SIGNAL_RELAY_E(re),
        .FAR_END_N(far), .STATUS_POLL(poll), .STATUS_VALID(valid), .STATUS_CHANGE(chg)
    );
    emtrk_bus_model bus_u (
        .clk(clk), .oe_n(oe_n), .dout(dout), .bclk(bclk), .fsync(fsync), .din(din),
        .idx(idx)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task poll_chk(input logic [7:0] exp);
        @(posedge clk) poll <= 1'b1;
        @(posedge clk) poll <= 1'b0;
        #1 chk8({7'h0, valid}, 8'h01);
        chk8(chg, exp);
        @(posedge clk) #1 chk8({7'h0, valid}, 8'h00);
    endtask : poll_chk

    // Codec frame: MSB first at falls, starting at the frame strobe
    task grab;
        @(posedge cfs);
        for (int i = 0; i < 8; i++) begin
            @(negedge cclk);
            for (int p = 0; p < 8; p++) heard[p] = {heard[p][6:0], cdout[p]};
        end
    endtask : grab

    // ************************************************************
    // Slot monitor: drive only in own slot, base wraps past slot 31
    // ************************************************************
    always @(negedge bclk) begin
        off = idx[7:3] - base;
        for (int b = 0; b < 2; b++) begin
            if (armed) chk8({7'h0, oe_n[b]}, {7'h0, !(off < 5'h08 && txb[off[2:0]] == b[0])});
            if (armed && !oe_n[b]) chk8({7'h0, dout[b]}, {7'h0, cdin[off[2:0]]});
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        cyc(4);
        chk8({6'h0, oe_n}, 8'h03);
        chk8(far, 8'hFF);
        cyc(4);
        rst_n <= 1'b1;
        cyc(3);
        for (int t = 0; t < 2; t++) begin
            trunk <= t[0];
            mu <= t[0];
            relay <= 8'hA5;
            cyc(3);
            chk8(rm, 8'hA5 & {8{t[0]}});
            chk8(re, 8'hA5 & {8{!t[0]}});
            chk8({7'h0, cmu}, {7'h0, t[0]});
        end
        c0 = ccnt;
        cyc(10000);
        chk8({7'h0, ccnt - c0 >= 511 && ccnt - c0 <= 513}, 8'h01);
        det_e_n <= 8'hF6;
        det_m_n <= 8'h00;
        cyc(6);
        chk8(far, 8'hF6);
        poll_chk(8'h09);
        poll_chk(8'h00);
        trunk <= 1'b0;
        cyc(6);
        chk8(far, 8'h00);
        poll_chk(8'hF6);
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 8; p++) begin
                lbus[p] <= p[0] ^ r[0];
                lslot[5*p +: 5] <= 5'(8 + 3 * p);
            end
            cyc(18432);
            armed <= 1'b1;
            grab();
            for (int p = 0; p < 8; p++) chk8(heard[p], {p[0] ^ r[0], 2'b10, 5'(8 + 3 * p)});
        end
        finish_test();
    end
endmodule : test_emtrk_top
